// file: logic/scc_pkg.sv
// Types and constants for the switch channel configuration register bank.
// Assumes a single mclk domain; serial pins are already synchronous to mclk.
// Notes on behaviour
// R1: Switching, fault and overcurrent registers exist per output; frame select picks one copy.
// R2: Direct-input disable 0 lets direct input drive output; 1 leaves only on bit.
// R3: Slew code 00 medium, 01 low, 10 high; 11 unused.
// R4: Delay bits give PWM clock rising edges of delay, only while PWM enabled.
// R5: Unlimited-retry bit disables the retry timer; resets to 1.
// R6: Retry-disable bit 1 stops auto-retry after a fault; default 0.
// R7: Short-to-supply disable bit 1 turns that protection off; default 0.
// R8: On open-load off when disable set; else LED bit picks bulb or LED threshold.
// R9: Off-state open-load disable bit 1 stops off-state detection; default 0.
// R10: Sense-ratio bit 0 low ratio, 1 high ratio.
// R11: Xenon bit 1 selects xenon overcurrent profile instead of bulb profile.
// R12: Cooling code 00 medium, 01 slow, 10 fast, 11 medium.
// R13: Inrush code 00 slow, 01 fast, 10 medium, 11 very slow.
// R14: High-level swap bit uses second high threshold during first overcurrent window.
// R15: Steady code 00 level 2, 01 level 3, 10 level 4, 11 level 1.
// R16: Overcurrent mode 0 inrush only, 1 inrush plus bulb cooling.
// R17: Supply-fail enable with low logic supply enters fail-safe, outputs from PWM registers.
// R18: PWM enable drives all outputs from PWM registers, ignoring direct inputs.
// R19: With PWM on, clock select 0 external on direct input 0, 1 internal oscillator.
// R20: Current enable routes selected output current; else temperature enable; else tri-state.
// R21: Overvoltage-disable bit 1 turns overvoltage protection off; default 0.
// R22: Decode 00101 global, 00111 calibration; per-output addresses 010, 011, 100.
// R23: Frame: watchdog toggle, two select bits, three address bits, zero bit, nine data.
// R24: Registers latch only on chip select rise after a multiple of sixteen bits.
package scc_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CHANNELS   = 4;

	localparam logic [2:0] ADDR_SWITCH = 3'h2;
	localparam logic [2:0] ADDR_FAULT  = 3'h3;
	localparam logic [2:0] ADDR_OVERC  = 3'h4;
	localparam logic [2:0] ADDR_GLOBAL = 3'h5;
	localparam logic [2:0] ADDR_CALIB  = 3'h7;
	localparam logic [1:0] SEL_GLOBAL  = 2'h0;

	typedef struct packed {
		logic       watchdog_toggle;
		logic [1:0] out_sel;
		logic [2:0] addr;
		logic       zero;
		logic [8:0] data;
	} scc_frame_t;

	typedef struct packed {
		logic       pad2;
		logic       pad1;
		logic       pad0;
		logic       direct_disable;
		logic [1:0] slew;
		logic [2:0] delay;
	} scc_switch_t;

	typedef struct packed {
		logic       pad1;
		logic       pad0;
		logic       retry_unlimited;
		logic       retry_disable;
		logic       supply_short_protect_off;
		logic       on_openload_off;
		logic       off_openload_off;
		logic       openload_led_threshold;
		logic       sense_ratio_select;
	} scc_fault_t;

	typedef struct packed {
		logic       xenon;
		logic [1:0] cooling_curve;
		logic [1:0] inrush_curve;
		logic       high_level_swap;
		logic [1:0] steady_limit_sel;
		logic       overcurrent_mode_select;
	} scc_overc_t;

	typedef struct packed {
		logic       supply_fail_enable;
		logic       pwm_enable;
		logic       clock_select;
		logic       temp_feedback_enable;
		logic       current_feedback_enable;
		logic [1:0] feedback_output_sel;
		logic       unused;
		logic       overvoltage_protect_off;
	} scc_global_t;

	localparam scc_switch_t RST_SWITCH = 9'h000;
	localparam scc_fault_t  RST_FAULT  = 9'h040;
	localparam scc_overc_t  RST_OVERC  = 9'h000;
	localparam scc_global_t RST_GLOBAL = 9'h000;
	localparam logic [8:0]  RST_CALIB  = 9'h000;

	typedef enum logic [1:0] {SCC_SLEW_MEDIUM, SCC_SLEW_LOW, SCC_SLEW_HIGH, SCC_SLEW_UNUSED} scc_slew_t;
	typedef enum logic [1:0] {SCC_OL_OFF, SCC_OL_BULB, SCC_OL_LED} scc_openload_t;
	typedef enum logic [1:0] {SCC_COOL_MEDIUM, SCC_COOL_SLOW, SCC_COOL_FAST} scc_cooling_t;
	typedef enum logic [1:0] {SCC_INR_SLOW, SCC_INR_FAST, SCC_INR_MEDIUM, SCC_INR_VSLOW} scc_inrush_t;
	typedef enum logic [1:0] {SCC_LIM_1, SCC_LIM_2, SCC_LIM_3, SCC_LIM_4} scc_steady_t;
	typedef enum logic [1:0] {SCC_FB_OFF, SCC_FB_CURRENT, SCC_FB_TEMP} scc_feedback_t;

	typedef struct packed {
		scc_slew_t     slew;
		logic          retry_enable;
		logic          retry_timer_enable;
		logic          supply_short_protect_on;
		scc_openload_t on_openload;
		logic          off_openload_on;
		logic          high_sense_ratio;
		logic          xenon_profile;
		scc_cooling_t  cooling;
		scc_inrush_t   inrush;
		logic          second_high_threshold;
		scc_steady_t   steady;
		logic          cooling_managed;
	} scc_ch_ctrl_t;
endpackage : scc_pkg

// file: logic/scc_config_regs.sv
// Serial-written configuration bank of a four-channel high-side switch.
// Assumes serial pins, direct inputs and the oscillator tick are synchronous to mclk.
`timescale 1ns/10ps
module scc_config_regs #(
	parameter int CHANNELS = scc_pkg::CHANNELS
) (
	// Clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  nrst,
	// Serial interface from the host
	input  wire logic                                  spi_cs_n,
	input  wire logic                                  spi_sclk,
	input  wire logic                                  spi_mosi,
	// Switching sources
	input  wire logic [CHANNELS-1:0]                   direct_in,
	input  wire logic [CHANNELS-1:0]                   pwm_drive,
	input  wire logic [CHANNELS-1:0]                   on_bit,
	input  wire logic                                  internal_osc,
	input  wire logic                                  vdd_fail,
	// Decoded controls
	output logic      [CHANNELS-1:0]                   out_gate,
	output scc_pkg::scc_ch_ctrl_t [CHANNELS-1:0]       ch_ctrl,
	output scc_pkg::scc_feedback_t                     feedback_mode,
	output logic      [1:0]                            feedback_channel,
	output logic                                       failsafe,
	output logic                                       pwm_active,
	output logic                                       pwm_clk_internal,
	output logic                                       overvoltage_protect_on,
	output logic      [8:0]                            clock_calibration,
	output logic                                       watchdog_toggle
);
	if (CHANNELS != 4) begin : gen_bad_channels
		$error("scc_config_regs: two select bits address exactly four channels");
	end

	// Serial receive state
	logic [15:0]       shift;
	logic [15:0]       next_shift;
	logic [3:0]        bit_cnt;
	logic [3:0]        next_bit_cnt;
	logic              seen;
	logic              next_seen;
	logic              sclk_q;
	logic              next_sclk_q;
	logic              cs_q;
	logic              next_cs_q;
	logic              commit;
	logic              next_commit;
	scc_pkg::scc_frame_t frame;

	always_comb begin
		next_shift   = shift;
		next_bit_cnt = bit_cnt;
		next_seen    = seen;
		next_sclk_q  = spi_sclk;
		next_cs_q    = spi_cs_n;
		next_commit  = 1'b0;
		if (cs_q && !spi_cs_n) begin
			next_bit_cnt = 4'h0;
			next_seen    = 1'b0;
		end else if (!spi_cs_n && spi_sclk && !sclk_q) begin
			next_shift   = {shift[14:0], spi_mosi};
			next_bit_cnt = bit_cnt + 4'h1;
			next_seen    = 1'b1;
		end
		// A short or ragged frame is dropped whole, so a glitch never half-writes a register
		if (!cs_q && spi_cs_n && seen && bit_cnt == 4'h0)  // see R24
			next_commit = 1'b1;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shift   <= 16'h0000;
			bit_cnt <= 4'h0;
			seen    <= 1'b0;
			sclk_q  <= 1'b0;
			cs_q    <= 1'b1;
			commit  <= 1'b0;
		end else begin
			shift   <= next_shift;
			bit_cnt <= next_bit_cnt;
			seen    <= next_seen;
			sclk_q  <= next_sclk_q;
			cs_q    <= next_cs_q;
			commit  <= next_commit;
		end
	end

	assign frame = scc_pkg::scc_frame_t'(shift);  // see R23

	// Configuration registers
	scc_pkg::scc_switch_t [CHANNELS-1:0] sw_cfg;
	scc_pkg::scc_switch_t [CHANNELS-1:0] next_sw_cfg;
	scc_pkg::scc_fault_t  [CHANNELS-1:0] fault_cfg;
	scc_pkg::scc_fault_t  [CHANNELS-1:0] next_fault_cfg;
	scc_pkg::scc_overc_t  [CHANNELS-1:0] oc_cfg;
	scc_pkg::scc_overc_t  [CHANNELS-1:0] next_oc_cfg;
	scc_pkg::scc_global_t                glb_cfg;
	scc_pkg::scc_global_t                next_glb_cfg;
	logic [8:0]                          cal_cfg;
	logic [8:0]                          next_cal_cfg;
	logic                                wd_bit;
	logic                                next_wd_bit;

	always_comb begin
		next_sw_cfg    = sw_cfg;
		next_fault_cfg = fault_cfg;
		next_oc_cfg    = oc_cfg;
		next_glb_cfg   = glb_cfg;
		next_cal_cfg   = cal_cfg;
		next_wd_bit    = wd_bit;
		if (commit) begin
			next_wd_bit = frame.watchdog_toggle;
			if (frame.addr == scc_pkg::ADDR_SWITCH) begin  // see R22
				next_sw_cfg[frame.out_sel] = scc_pkg::scc_switch_t'(frame.data);  // see R1
			end else if (frame.addr == scc_pkg::ADDR_FAULT) begin
				next_fault_cfg[frame.out_sel] = scc_pkg::scc_fault_t'(frame.data);
			end else if (frame.addr == scc_pkg::ADDR_OVERC) begin
				next_oc_cfg[frame.out_sel] = scc_pkg::scc_overc_t'(frame.data);
			end else if (frame.addr == scc_pkg::ADDR_GLOBAL
				&& frame.out_sel == scc_pkg::SEL_GLOBAL) begin  // see R22
				next_glb_cfg = scc_pkg::scc_global_t'(frame.data);
			end else if (frame.addr == scc_pkg::ADDR_CALIB
				&& frame.out_sel == scc_pkg::SEL_GLOBAL) begin
				next_cal_cfg = frame.data;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				sw_cfg[i]    <= scc_pkg::RST_SWITCH;
				fault_cfg[i] <= scc_pkg::RST_FAULT;  // see R5
				oc_cfg[i]    <= scc_pkg::RST_OVERC;
			end
			glb_cfg <= scc_pkg::RST_GLOBAL;
			cal_cfg <= scc_pkg::RST_CALIB;
			wd_bit  <= 1'b0;
		end else begin
			sw_cfg    <= next_sw_cfg;
			fault_cfg <= next_fault_cfg;
			oc_cfg    <= next_oc_cfg;
			glb_cfg   <= next_glb_cfg;
			cal_cfg   <= next_cal_cfg;
			wd_bit    <= next_wd_bit;
		end
	end

	// PWM clock edge detection; the external clock shares pin direct input 0
	logic pwm_src;
	logic pwm_src_q;
	logic next_pwm_src_q;
	logic pwm_edge;

	always_comb begin
		pwm_src        = glb_cfg.clock_select ? internal_osc : direct_in[0];  // see R19
		next_pwm_src_q = pwm_src;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			pwm_src_q <= 1'b0;
		else
			pwm_src_q <= next_pwm_src_q;
	end

	assign pwm_edge = glb_cfg.pwm_enable && pwm_src && !pwm_src_q;

	// Per-channel switching path and decoded controls
	logic                          fs_mode;
	logic [CHANNELS-1:0]           next_gate;
	scc_pkg::scc_ch_ctrl_t [CHANNELS-1:0] next_ctrl;

	assign fs_mode = glb_cfg.supply_fail_enable && vdd_fail;  // see R17

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			logic [6:0] hist;
			logic [6:0] next_hist;
			logic       req;
			logic       delayed;

			always_comb begin
				// Which source owns the output, in falling priority
				if (fs_mode || glb_cfg.pwm_enable)  // see R17, see R18
					req = pwm_drive[g];
				else if (sw_cfg[g].direct_disable)  // see R2
					req = on_bit[g];
				else
					req = direct_in[g] | on_bit[g];
				next_hist = pwm_edge ? {hist[5:0], req} : hist;
				// Delay only counts PWM edges, so it is meaningless with PWM off
				if (!glb_cfg.pwm_enable || sw_cfg[g].delay == 3'h0)  // see R4
					delayed = req;
				else
					delayed = hist[sw_cfg[g].delay - 3'h1];
				next_gate[g] = delayed;
			end

			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst)
					hist <= 7'h00;
				else
					hist <= next_hist;
			end

			always_comb begin
				next_ctrl[g].slew = scc_pkg::scc_slew_t'(sw_cfg[g].slew);  // see R3
				next_ctrl[g].retry_enable = !fault_cfg[g].retry_disable;  // see R6
				next_ctrl[g].retry_timer_enable = !fault_cfg[g].retry_unlimited;  // see R5
				next_ctrl[g].supply_short_protect_on =
					!fault_cfg[g].supply_short_protect_off;  // see R7
				if (fault_cfg[g].on_openload_off)  // see R8
					next_ctrl[g].on_openload = scc_pkg::SCC_OL_OFF;
				else if (fault_cfg[g].openload_led_threshold)
					next_ctrl[g].on_openload = scc_pkg::SCC_OL_LED;
				else
					next_ctrl[g].on_openload = scc_pkg::SCC_OL_BULB;
				next_ctrl[g].off_openload_on = !fault_cfg[g].off_openload_off;  // see R9
				next_ctrl[g].high_sense_ratio = fault_cfg[g].sense_ratio_select;  // see R10
				next_ctrl[g].xenon_profile = oc_cfg[g].xenon;  // see R11
				case (oc_cfg[g].cooling_curve)  // see R12
					2'h1:    next_ctrl[g].cooling = scc_pkg::SCC_COOL_SLOW;
					2'h2:    next_ctrl[g].cooling = scc_pkg::SCC_COOL_FAST;
					default: next_ctrl[g].cooling = scc_pkg::SCC_COOL_MEDIUM;
				endcase
				next_ctrl[g].inrush = scc_pkg::scc_inrush_t'(oc_cfg[g].inrush_curve);  // see R13
				next_ctrl[g].second_high_threshold = oc_cfg[g].high_level_swap;  // see R14
				case (oc_cfg[g].steady_limit_sel)  // see R15
					2'h0:    next_ctrl[g].steady = scc_pkg::SCC_LIM_2;
					2'h1:    next_ctrl[g].steady = scc_pkg::SCC_LIM_3;
					2'h2:    next_ctrl[g].steady = scc_pkg::SCC_LIM_4;
					default: next_ctrl[g].steady = scc_pkg::SCC_LIM_1;
				endcase
				next_ctrl[g].cooling_managed = oc_cfg[g].overcurrent_mode_select;  // see R16
			end
		end
	endgenerate

	// Registered outputs
	scc_pkg::scc_feedback_t next_fb_mode;

	always_comb begin
		if (glb_cfg.current_feedback_enable)  // see R20
			next_fb_mode = scc_pkg::SCC_FB_CURRENT;
		else if (glb_cfg.temp_feedback_enable)
			next_fb_mode = scc_pkg::SCC_FB_TEMP;
		else
			next_fb_mode = scc_pkg::SCC_FB_OFF;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			out_gate               <= '0;
			ch_ctrl                <= '0;
			feedback_mode          <= scc_pkg::SCC_FB_OFF;
			feedback_channel       <= 2'h0;
			failsafe               <= 1'b0;
			pwm_active             <= 1'b0;
			pwm_clk_internal       <= 1'b0;
			overvoltage_protect_on <= 1'b1;
			clock_calibration      <= scc_pkg::RST_CALIB;
			watchdog_toggle        <= 1'b0;
		end else begin
			out_gate               <= next_gate;
			ch_ctrl                <= next_ctrl;
			feedback_mode          <= next_fb_mode;
			feedback_channel       <= glb_cfg.feedback_output_sel;
			failsafe               <= fs_mode;
			pwm_active             <= glb_cfg.pwm_enable;
			pwm_clk_internal       <= glb_cfg.pwm_enable && glb_cfg.clock_select;  // see R19
			overvoltage_protect_on <= !glb_cfg.overvoltage_protect_off;  // see R21
			clock_calibration      <= cal_cfg;
			watchdog_toggle        <= wd_bit;
		end
	end
endmodule : scc_config_regs

// file: bench/scc_host_model.sv
// Serial host master that writes frames into the configuration bank.
// Assumes mclk comes from the bench; pins change only at falling mclk.
`timescale 1ns/10ps
module scc_host_model (
	// Clock
	input  wire logic mclk,
	// Serial pins
	output logic      spi_cs_n,
	output logic      spi_sclk,
	output logic      spi_mosi
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
	end

	// Sends the low n bits of f; a count other than 16 is a deliberate bad length
	task automatic send(input logic [15:0] f, input int n);
		@(negedge mclk);
		spi_cs_n = 1'b0;
		repeat (2) @(negedge mclk);
		for (int b = n - 1; b >= 0; b--) begin
			spi_mosi = f[b];
			repeat (2) @(negedge mclk);
			spi_sclk = 1'b1;
			repeat (2) @(negedge mclk);
			spi_sclk = 1'b0;
		end
		repeat (2) @(negedge mclk);
		spi_cs_n = 1'b1;
		// Released line must not keep the last bit
		spi_mosi = ~spi_mosi;
		repeat (6) @(negedge mclk);
	endtask : send
endmodule : scc_host_model

// file: bench/scc_config_regs_sva.sv
// Port-level checks for the configuration bank.
// Assumes one mclk domain; bound to every bank instance.
`timescale 1ns/10ps
module scc_config_regs_sva #(
	parameter int CHANNELS = 4
) (
	input wire logic                                mclk,
	input wire logic                                nrst,
	input wire logic                                spi_cs_n,
	input wire logic [CHANNELS-1:0]                 direct_in,
	input wire logic [CHANNELS-1:0]                 pwm_drive,
	input wire logic [CHANNELS-1:0]                 on_bit,
	input wire logic                                vdd_fail,
	input wire logic [CHANNELS-1:0]                 out_gate,
	input wire scc_pkg::scc_ch_ctrl_t [CHANNELS-1:0] ch_ctrl,
	input wire scc_pkg::scc_feedback_t              feedback_mode,
	input wire logic                                failsafe,
	input wire logic                                pwm_active,
	input wire logic                                pwm_clk_internal,
	input wire logic [8:0]                          clock_calibration,
	input wire logic                                watchdog_toggle
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_quiet; spi_cs_n [*5]; endsequence
	sequence s_direct; (!pwm_active && !vdd_fail) [*2]; endsequence
	sequence s_fs; (failsafe && vdd_fail && !pwm_active) [*2]; endsequence

	property p_hold; s_quiet |-> $stable(clock_calibration) && $stable(watchdog_toggle); endproperty
	property p_on; s_direct ##0 on_bit == '1 |=> out_gate == '1; endproperty
	property p_off; s_direct ##0 (on_bit | direct_in) == '0 |=> out_gate == '0; endproperty
	property p_fs_gate; !vdd_fail |=> !failsafe; endproperty
	property p_fs_drive; s_fs |=> out_gate == $past(pwm_drive); endproperty
	property p_clk; pwm_clk_internal |-> pwm_active; endproperty
	property p_fb; feedback_mode != 2'h3; endproperty
	property p_cool;
		ch_ctrl[0].cooling != 2'h3 && ch_ctrl[1].cooling != 2'h3 &&
		ch_ctrl[2].cooling != 2'h3 && ch_ctrl[3].cooling != 2'h3;
	endproperty

	a_hold: assert property (p_hold) else $error("register changed without a frame");
	a_on: assert property (p_on) else $error("on bit did not switch output");
	a_off: assert property (p_off) else $error("output on with no source");
	a_fs_gate: assert property (p_fs_gate) else $error("failsafe without supply fail");
	a_fs_drive: assert property (p_fs_drive) else $error("failsafe not from pwm");
	a_clk: assert property (p_clk) else $error("clock select with pwm off");
	a_fb: assert property (p_fb) else $error("illegal feedback mode");
	a_cool: assert property (p_cool) else $error("illegal cooling code");
endmodule : scc_config_regs_sva

bind scc_config_regs scc_config_regs_sva #(.CHANNELS(CHANNELS)) i_scc_config_regs_sva (
	.mclk(mclk), .nrst(nrst), .spi_cs_n(spi_cs_n), .direct_in(direct_in),
	.pwm_drive(pwm_drive), .on_bit(on_bit), .vdd_fail(vdd_fail), .out_gate(out_gate),
	.ch_ctrl(ch_ctrl), .feedback_mode(feedback_mode), .failsafe(failsafe),
	.pwm_active(pwm_active), .pwm_clk_internal(pwm_clk_internal),
	.clock_calibration(clock_calibration), .watchdog_toggle(watchdog_toggle)
);

// file: bench/tb_top.sv
// Self-checking bench for the configuration bank.
// Assumes the host model drives the serial pins; other inputs change at falling mclk.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_top;
	logic                          mclk = 1'b0;
	logic                          nrst = 1'b0;
	logic                          spi_cs_n, spi_sclk, spi_mosi;
	logic [3:0]                    direct_in = '0, pwm_drive = '0, on_bit = '0, out_gate;
	logic                          internal_osc = 1'b0, vdd_fail = 1'b0, wd = 1'b0;
	logic                          failsafe, pwm_active, pwm_clk_internal, ovp_on, wdt;
	scc_pkg::scc_ch_ctrl_t [3:0]   ch_ctrl;
	scc_pkg::scc_ch_ctrl_t         exp_c [4];
	scc_pkg::scc_feedback_t        fb_mode;
	logic [1:0]                    fb_ch, kk;
	logic [8:0]                    calib;
	logic [8:0]                    fv [4] = '{9'h000, 9'h04A, 9'h032, 9'h005};
	scc_pkg::scc_cooling_t         cool_t [4] = '{scc_pkg::SCC_COOL_MEDIUM,
		scc_pkg::SCC_COOL_SLOW, scc_pkg::SCC_COOL_FAST, scc_pkg::SCC_COOL_MEDIUM};
	scc_pkg::scc_inrush_t          inr_t [4] = '{scc_pkg::SCC_INR_SLOW,
		scc_pkg::SCC_INR_FAST, scc_pkg::SCC_INR_MEDIUM, scc_pkg::SCC_INR_VSLOW};
	scc_pkg::scc_steady_t          st_t [4] = '{scc_pkg::SCC_LIM_2,
		scc_pkg::SCC_LIM_3, scc_pkg::SCC_LIM_4, scc_pkg::SCC_LIM_1};
	int                            failures = 0, num_checks = 0;

	always #5 mclk = ~mclk;
	always @(negedge mclk) internal_osc <= ~internal_osc;

	scc_host_model i_scc_host_model (.mclk(mclk), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi));

	scc_config_regs i_scc_config_regs (.mclk(mclk), .nrst(nrst), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .direct_in(direct_in),
		.pwm_drive(pwm_drive), .on_bit(on_bit), .internal_osc(internal_osc),
		.vdd_fail(vdd_fail), .out_gate(out_gate), .ch_ctrl(ch_ctrl),
		.feedback_mode(fb_mode), .feedback_channel(fb_ch), .failsafe(failsafe),
		.pwm_active(pwm_active), .pwm_clk_internal(pwm_clk_internal),
		.overvoltage_protect_on(ovp_on), .clock_calibration(calib), .watchdog_toggle(wdt));

	function automatic scc_pkg::scc_ch_ctrl_t fault_exp(input scc_pkg::scc_ch_ctrl_t c,
		input logic [8:0] d);
		c.retry_timer_enable = !d[6];
		c.retry_enable = !d[5];
		c.supply_short_protect_on = !d[4];
		c.on_openload = d[3] ? scc_pkg::SCC_OL_OFF : d[1] ? scc_pkg::SCC_OL_LED : scc_pkg::SCC_OL_BULB;
		c.off_openload_on = !d[2];
		c.high_sense_ratio = d[0];
		return c;
	endfunction : fault_exp

	task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [8:0] d);
		wd = ~wd;
		i_scc_host_model.send({wd, s, a, 1'b0, d}, 16);
		`CHK("watchdog_toggle", wd, wdt)
	endtask : wr

	task automatic check_all();
		for (int i = 0; i < 4; i++) `CHK("ch_ctrl", exp_c[i], ch_ctrl[i])
	endtask : check_all

	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	initial begin
		#200000;
		failures++;
		stop_test();
	end

	initial begin
		exp_c[0] = '0;
		exp_c[0].steady = scc_pkg::SCC_LIM_2;
		exp_c[0] = fault_exp(exp_c[0], 9'h040);
		exp_c[1] = exp_c[0];
		exp_c[2] = exp_c[0];
		exp_c[3] = exp_c[0];
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		repeat (3) @(negedge mclk);
		check_all();
		`CHK("ovp_on", 1'b1, ovp_on)
		`CHK("fb_mode", scc_pkg::SCC_FB_OFF, fb_mode)
		for (int k = 0; k < 4; k++) begin
			kk = 2'(k);
			wr(kk, scc_pkg::ADDR_FAULT, fv[k]);
			exp_c[k] = fault_exp(exp_c[k], fv[k]);
			check_all();
			wr(kk, scc_pkg::ADDR_OVERC, {kk[0], kk, kk, kk[1], kk, kk[0]});
			exp_c[k].xenon_profile = kk[0];
			exp_c[k].cooling = cool_t[k];
			exp_c[k].inrush = inr_t[k];
			exp_c[k].second_high_threshold = kk[1];
			exp_c[k].steady = st_t[k];
			exp_c[k].cooling_managed = kk[0];
			check_all();
			wr(kk, scc_pkg::ADDR_SWITCH, {4'h0, (k == 3) ? 2'h0 : kk, 3'h0});
			exp_c[k].slew = scc_pkg::scc_slew_t'((k == 3) ? 2'h0 : kk);
			check_all();
		end
		wr(2'h3, scc_pkg::ADDR_SWITCH, 9'h020);
		direct_in = 4'hF;
		repeat (4) @(negedge mclk);
		`CHK("out_gate", 4'h7, out_gate)
		on_bit = 4'h8;
		repeat (4) @(negedge mclk);
		`CHK("out_gate", 4'hF, out_gate)
		on_bit = 4'hF;
		direct_in = 4'h0;
		repeat (4) @(negedge mclk);
		`CHK("out_gate", 4'hF, out_gate)
		wr(2'h0, scc_pkg::ADDR_CALIB, 9'h1A5);
		`CHK("calib", 9'h1A5, calib)
		wr(2'h1, scc_pkg::ADDR_CALIB, 9'h0FF);
		wr(2'h2, scc_pkg::ADDR_GLOBAL, 9'h080);
		wr(2'h0, 3'h0, 9'h1FF);
		wr(2'h1, 3'h6, 9'h1FF);
		i_scc_host_model.send({~wd, 2'h0, scc_pkg::ADDR_GLOBAL, 1'b0, 9'h080}, 15);
		`CHK("calib", 9'h1A5, calib)
		`CHK("pwm_active", 1'b0, pwm_active)
		`CHK("watchdog_toggle", wd, wdt)
		check_all();
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h01C);
		`CHK("fb_mode", scc_pkg::SCC_FB_CURRENT, fb_mode)
		`CHK("fb_ch", 2'h3, fb_ch)
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h020);
		`CHK("fb_mode", scc_pkg::SCC_FB_TEMP, fb_mode)
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h038);
		`CHK("fb_ch", 2'h2, fb_ch)
		`CHK("fb_mode", scc_pkg::SCC_FB_CURRENT, fb_mode)
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h001);
		`CHK("ovp_on", 1'b0, ovp_on)
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h100);
		pwm_drive = 4'h9;
		vdd_fail = 1'b1;
		repeat (4) @(negedge mclk);
		`CHK("failsafe", 1'b1, failsafe)
		`CHK("out_gate", 4'h9, out_gate)
		vdd_fail = 1'b0;
		on_bit = 4'h5;
		direct_in = 4'hA;
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h0C0);
		`CHK("pwm_clk_internal", 1'b1, pwm_clk_internal)
		pwm_drive = 4'h6;
		repeat (6) @(negedge mclk);
		`CHK("out_gate", 4'h6, out_gate)
		// Channel 1 waits three PWM clock edges; the others follow at once
		wr(2'h1, scc_pkg::ADDR_SWITCH, 9'h00B);
		pwm_drive = 4'h4;
		repeat (2) @(negedge mclk);
		`CHK("out_gate", 4'h6, out_gate)
		repeat (10) @(negedge mclk);
		`CHK("out_gate", 4'h4, out_gate)
		wr(2'h0, scc_pkg::ADDR_GLOBAL, 9'h080);
		`CHK("pwm_clk_internal", 1'b0, pwm_clk_internal)
		`CHK("pwm_active", 1'b1, pwm_active)
		// External clock now: no edges on direct input 0 means the delayed channel holds
		pwm_drive = 4'h6;
		repeat (10) @(negedge mclk);
		`CHK("out_gate", 4'h4, out_gate)
		repeat (3) begin
			direct_in[0] = 1'b1;
			repeat (2) @(negedge mclk);
			direct_in[0] = 1'b0;
			repeat (2) @(negedge mclk);
		end
		`CHK("out_gate", 4'h6, out_gate)
		stop_test();
	end
endmodule : tb_top
